// File: esdrv_drv_model.sv
`timescale 1ns/1ps
module esdrv_drv_model
   import esdrv_pkg::*;
(
   // Pins in, position out
   input wire logic clk_i,
   input wire logic rst_i,
   input wire esdrv_pins_type pins_i,
   output int pos_o
);
   logic s_q;
   // Pulses span hundreds of cycles, so sampling on the system clock is safe
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q <= 1'b0;
         pos_o <= 0;
      end else begin
         s_q <= pins_i.step;
         if (pins_i.step && !s_q && pins_i.en) begin
            pos_o <= pos_o + (pins_i.dir ? 1 : -1);
         end
      end
   end
endmodule

// File: esdrv_params.svh
`ifndef ESDRV_PARAMS_SVH
`define ESDRV_PARAMS_SVH
// Behaviour
// - While external control is active the port drives just three outputs: enable, direction and step clock.
// - One step clock pulse is sent per microstep, so the pulse count equals the commanded displacement.
// - Direction is high for motion to the right and low for motion to the left.
// - The microsteps per full step follow the division, 32 pulses per step at 1/32.
// - Step clock pulses never come faster than 78 kHz, whatever rate is asked for.
// - The port runs only for a stepper motor with feedback set to none.
// - While external control is enabled the shared general-purpose pin loses its own input and output use.
`define ESDRV_CLK_HZ 100000000
`define ESDRV_MAX_STEP_HZ 78000
// Least pulse period, rounded up to whole cycles
`define ESDRV_MIN_PERIOD_CYC ((`ESDRV_CLK_HZ + `ESDRV_MAX_STEP_HZ - 1) / `ESDRV_MAX_STEP_HZ)
`define ESDRV_HIGH_CYC (`ESDRV_MIN_PERIOD_CYC / 2)
`define ESDRV_MOTOR_STEPPER 2'h0
`define ESDRV_FB_NONE 2'h0
`define ESDRV_DIV_MAX_LOG2 3'h7
`endif

// File: esdrv_pkg.sv
package esdrv_pkg;
   typedef struct packed {
      logic en;
      logic dir;
      logic step;
   } esdrv_pins_type;
   typedef enum logic [2:0] {
      ESDRV_IDLE = 3'b001,
      ESDRV_HIGH = 3'b010,
      ESDRV_LOW = 3'b100
   } esdrv_state_type;
endpackage

// File: esdrv_port.sv
`timescale 1ns/1ps
`include "esdrv_params.svh"
module esdrv_port
   import esdrv_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // Mode configuration
   input wire logic ext_enable_i,
   input wire logic [1:0] motor_type_i,
   input wire logic [1:0] feedback_i,
   input wire logic [2:0] div_log2_i,
   // Move command
   input wire logic move_start_i,
   input wire logic move_dir_right_i,
   input wire logic [23:0] move_full_steps_i,
   input wire logic [15:0] move_period_i,
   // Shared pin from general-purpose logic
   input wire logic gpio_out_i,
   input wire logic gpio_oe_i,
   output logic gpio_in_o,
   // Pins and status
   output esdrv_pins_type pins_o,
   output logic shared_gpio_pin_o,
   output logic shared_gpio_pin_oe_o,
   output logic busy_o,
   output logic done_o
);
   // Cycle counts fixed by the system clock and the pulse-rate cap
   localparam logic [15:0] MIN_PERIOD = 16'(`ESDRV_MIN_PERIOD_CYC);
   localparam logic [15:0] HIGH_CYC = 16'(`ESDRV_HIGH_CYC);

   // True only for a stepper that runs with feedback set to none
   function automatic logic open_loop(input logic [1:0] motor, input logic [1:0] fb);
      open_loop = (motor == `ESDRV_MOTOR_STEPPER) && (fb == `ESDRV_FB_NONE);
   endfunction

   // Microsteps of a move; the division is capped so the shift stays in 32 bits
   function automatic logic [31:0] microsteps(input logic [23:0] full, input logic [2:0] div_log2);
      logic [2:0] div_cap;
      div_cap = (div_log2 > `ESDRV_DIV_MAX_LOG2) ? `ESDRV_DIV_MAX_LOG2 : div_log2;
      microsteps = 32'(full) << div_cap;
   endfunction

   // Raise a short period to the least legal one
   function automatic logic [15:0] clamp_period(input logic [15:0] req);
      clamp_period = (req < MIN_PERIOD) ? MIN_PERIOD : req;
   endfunction

   // Count down by one, resting at zero so an idle counter never wraps
   function automatic logic [15:0] count_down(input logic [15:0] c);
      count_down = (c == 16'h0) ? 16'h0 : c - 16'h1;
   endfunction

   // Sequencer state
   esdrv_state_type state_q;
   esdrv_state_type state_d;

   // Move bookkeeping
   logic [31:0] left_q;
   logic [31:0] left_d;
   logic [15:0] cnt_q;
   logic [15:0] cnt_d;
   logic [15:0] period_q;
   logic [15:0] period_d;
   logic dir_q;
   logic dir_d;

   // Registered outputs
   logic en_q;
   logic step_q;
   logic done_q;
   logic busy_q;
   logic gpio_in_q;
   logic pin_q;
   logic pin_oe_q;

   // Mode decode; anything but an open-loop stepper keeps the port quiet
   wire mode_ok = ext_enable_i && open_loop(motor_type_i, feedback_i);

   // Move decode
   wire [31:0] usteps = microsteps(move_full_steps_i, div_log2_i);
   wire [15:0] period_eff = clamp_period(move_period_i);
   wire start_ok = mode_ok && move_start_i && (usteps != 32'h0);

   // Phase events; each needs the mode still good, so a mode loss aborts
   wire cnt_end = (cnt_q == 16'h0001);
   wire last_pulse = (left_q == 32'h0000_0001);
   wire take = (state_q == ESDRV_IDLE) && start_ok;
   wire high_end = (state_q == ESDRV_HIGH) && mode_ok && cnt_end;
   wire low_end = (state_q == ESDRV_LOW) && mode_ok && cnt_end;
   wire finish = low_end && last_pulse;

   // Next state; a start while busy is simply not looked at
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ESDRV_IDLE: begin
            if (start_ok) begin
               state_d = ESDRV_HIGH;
            end
         end
         ESDRV_HIGH: begin
            if (!mode_ok) begin
               state_d = ESDRV_IDLE;
            end else if (cnt_end) begin
               state_d = ESDRV_LOW;
            end
         end
         ESDRV_LOW: begin
            if (!mode_ok) begin
               state_d = ESDRV_IDLE;
            end else if (cnt_end) begin
               state_d = last_pulse ? ESDRV_IDLE : ESDRV_HIGH;
            end
         end
      endcase
   end

   // Phase counter; the low phase takes what the period leaves after the high phase
   always_comb begin
      cnt_d = count_down(cnt_q);
      if (take || low_end) begin
         cnt_d = HIGH_CYC;
      end else if (high_end) begin
         cnt_d = period_q - HIGH_CYC;
      end
   end

   // Pulses still owed; one is paid at the end of each low phase
   always_comb begin
      left_d = left_q;
      if (take) begin
         left_d = usteps;
      end else if (low_end) begin
         left_d = left_q - 32'h1;
      end
   end

   // Period and direction latch only at the take, so both stay put all move long
   always_comb begin
      period_d = period_q;
      dir_d = dir_q;
      if (take) begin
         period_d = period_eff;
         dir_d = move_dir_right_i;
      end
   end

   // State register
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         state_q <= ESDRV_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // Phase counter register
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         cnt_q <= 16'h0;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   // Remaining pulse count
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         left_q <= 32'h0;
      end else begin
         left_q <= left_d;
      end
   end

   // Held period and direction
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         period_q <= MIN_PERIOD;
         dir_q <= 1'b0;
      end else begin
         period_q <= period_d;
         dir_q <= dir_d;
      end
   end

   // Step clock; gated by the mode too, so it can never outlive enable
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         step_q <= 1'b0;
      end else begin
         step_q <= (state_d == ESDRV_HIGH) && mode_ok;
      end
   end

   // Enable follows the mode one cycle late
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         en_q <= 1'b0;
      end else begin
         en_q <= mode_ok;
      end
   end

   // Busy and a one-cycle done; an aborted move gives no done
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         busy_q <= (state_d != ESDRV_IDLE);
         done_q <= finish;
      end
   end

   // Shared pin goes quiet while the driver port owns it
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         gpio_in_q <= 1'b0;
         pin_q <= 1'b0;
         pin_oe_q <= 1'b0;
      end else begin
         gpio_in_q <= ext_enable_i ? 1'b0 : gpio_out_i;
         pin_q <= ext_enable_i ? 1'b0 : gpio_out_i;
         pin_oe_q <= ext_enable_i ? 1'b0 : gpio_oe_i;
      end
   end

   // Three driver outputs, all from flops
   assign pins_o = '{en: en_q, dir: dir_q, step: step_q};

   // Status and shared pin outputs
   assign gpio_in_o = gpio_in_q;
   assign shared_gpio_pin_o = pin_q;
   assign shared_gpio_pin_oe_o = pin_oe_q;
   assign busy_o = busy_q;
   assign done_o = done_q;
endmodule

// File: esdrv_port_asserts.sv
`timescale 1ns/1ps
`include "esdrv_params.svh"
module esdrv_port_asserts
   import esdrv_pkg::*;
(
   // Clock and inputs
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic ext_enable_i,
   input wire logic [1:0] motor_type_i,
   input wire logic [1:0] feedback_i,
   input wire logic move_dir_right_i,
   // Outputs
   input wire esdrv_pins_type pins_o,
   input wire logic shared_gpio_pin_oe_o,
   input wire logic busy_o,
   input wire logic done_o
);
   int hi_q;
   int lo_q;
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   // High and low run lengths of the step clock; an abort drops en too, so it is excluded
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         hi_q <= 0;
         lo_q <= 0;
      end else begin
         hi_q <= pins_o.step ? hi_q + 1 : 0;
         lo_q <= (busy_o && !pins_o.step) ? lo_q + 1 : 0;
      end
   end
   sequence step_rise_s;
      $rose(pins_o.step);
   endsequence
   sequence step_fall_s;
      $fell(pins_o.step) && pins_o.en;
   endsequence
   property high_len_p;
      step_fall_s |-> hi_q == `ESDRV_HIGH_CYC;
   endproperty
   property low_len_p;
      step_rise_s |-> lo_q == 0 || lo_q >= (`ESDRV_MIN_PERIOD_CYC - `ESDRV_HIGH_CYC);
   endproperty
   low_len_a: assert property (low_len_p) else $error("low phase short");
   mode_bad_a: assert property ((motor_type_i != `ESDRV_MOTOR_STEPPER || feedback_i != `ESDRV_FB_NONE) |=> !pins_o.en) else $error("mode");
   abort_stop_a: assert property (!ext_enable_i |=> !pins_o.step && !busy_o) else $error("abort");
   en_off_a: assert property (!ext_enable_i |=> !pins_o.en) else $error("en");
   step_en_a: assert property (pins_o.step |-> pins_o.en) else $error("step");
   step_busy_a: assert property (pins_o.step |-> busy_o) else $error("idle");
   dir_hold_a: assert property (busy_o && $past(busy_o) |-> $stable(pins_o.dir)) else $error("dir");
   dir_set_a: assert property ($rose(busy_o) |-> pins_o.step && pins_o.dir == $past(move_dir_right_i)) else $error("start");
   high_len_a: assert property (high_len_p) else $error("high");
   pin_free_a: assert property (ext_enable_i |=> !shared_gpio_pin_oe_o) else $error("pin");
   done_end_a: assert property (done_o |-> $fell(busy_o) ##1 !done_o) else $error("done");
endmodule

// File: esdrv_tb.sv
`timescale 1ns/1ps
`include "esdrv_params.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; $display("mismatch %0t value off rule", $time); end end
module testbench;
   import esdrv_pkg::*;
   logic clk_i = 1'b0, sys_rst_i = 1'b1, ext_enable_i = 1'b1, move_start_i = 1'b0, move_dir_right_i = 1'b0;
   logic gpio_out_i = 1'b1, gpio_oe_i = 1'b1, gpio_in_o, shared_gpio_pin_o, shared_gpio_pin_oe_o, busy_o, done_o;
   logic [1:0] motor_type_i = 2'h0, feedback_i = 2'h0;
   logic [2:0] div_log2_i = 3'h0;
   logic [23:0] move_full_steps_i = 24'h0;
   logic [15:0] move_period_i = 16'h0064; // Faster than allowed, so the port must clamp
   esdrv_pins_type pins_o;
   int error_cnt = 0, n_tests = 0, cyc = 0, pos;
   esdrv_port esdrv_port_i(.*);
   esdrv_drv_model esdrv_drv_model_i(.clk_i, .rst_i(sys_rst_i), .pins_i(pins_o), .pos_o(pos));
   // Clock, and a ceiling about twice the planned run
   initial forever #5 clk_i = ~clk_i;
   always @(posedge clk_i) if (++cyc == 99000) stop_test(1);
   task automatic stop_test(input int t);
      error_cnt += t;
      $display("errors %0d checks %0d", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // One move, judged by the far side's microstep count and by its length in cycles
   task automatic move(input logic d, input logic [23:0] n, input logic [2:0] v, input logic [15:0] per);
      int p0;
      int k;
      int exp_per;
      k = 0;
      exp_per = (int'(per) < `ESDRV_MIN_PERIOD_CYC) ? `ESDRV_MIN_PERIOD_CYC : int'(per);
      @(posedge clk_i);
      p0 = pos;
      {move_dir_right_i, move_full_steps_i, div_log2_i, move_period_i, move_start_i} <= {d, n, v, per, 1'b1};
      @(posedge clk_i);
      move_start_i <= 1'b0;
      #1;
      while (done_o !== 1'b1) begin
         @(posedge clk_i);
         #1;
         k++;
      end
      `CHK(pos - p0, (d ? 1 : -1) * (int'(n) << v))
      `CHK(k, exp_per * (int'(n) << v))
   endtask
   // Mode loss aborts; wrong feedback or motor ignores start; leaving driver mode returns the pin
   task automatic guard();
      @(posedge clk_i);
      {div_log2_i, move_full_steps_i, move_start_i} <= {3'h2, 24'h1, 1'b1};
      @(posedge clk_i);
      move_start_i <= 1'b0;
      repeat (700) @(posedge clk_i);
      feedback_i <= 2'h1;
      repeat (2) @(posedge clk_i);
      #1 `CHK({busy_o, pins_o.en, pins_o.step, done_o}, 4'b0000)
      @(posedge clk_i);
      move_start_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      #1 `CHK({busy_o, pins_o.en}, 2'b00)
      @(posedge clk_i);
      {feedback_i, motor_type_i} <= {2'h0, 2'h1};
      repeat (3) @(posedge clk_i);
      #1 `CHK({busy_o, pins_o.en}, 2'b00)
      `CHK({shared_gpio_pin_o, shared_gpio_pin_oe_o, gpio_in_o}, 3'b000)
      @(posedge clk_i);
      {ext_enable_i, move_start_i} <= {1'b0, 1'b0};
      repeat (2) @(posedge clk_i);
      #1 `CHK({shared_gpio_pin_o, shared_gpio_pin_oe_o, gpio_in_o}, 3'b111)
   endtask
   initial begin
      repeat (16) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      move(1'b0, 24'h3, 3'h0, 16'h0064);
      move(1'b1, 24'h1, 3'h2, 16'h0064);
      // Division 1/32 only for a single step; faster moves would lower it
      move(1'b1, 24'h1, 3'h5, 16'h0064);
      move(1'b0, 24'h1, 3'h0, 16'h0503);
      move(1'b1, 24'h1, 3'h0, 16'h0600);
      guard();
      stop_test(0);
   end
endmodule
bind esdrv_port esdrv_port_asserts esdrv_port_asserts_i(.*);
